/* File: logic/cmb_manager.sv */
// Purpose: Message buffer store, receive staging, transmit selection, locking.
// Assumes: Link side is frame-level logic on pclk; APB slave, one wait state.
// Notes: Buffer b word w sits at byte 32*b + 4*w in the low half of the data.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module cmb_manager import cmb_pkg::*; (
  input wire logic pclk, // Clock, 200 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [9:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rx_valid, // Received frame strobe
  input wire logic [28:0] rx_id, // Received identifier
  input wire logic rx_ide, // Received frame is extended
  input wire logic rx_rtr, // Received frame is remote
  input wire logic rx_srr, // Received SRR bit
  input wire logic [3:0] rx_dlc, // Received length code
  input wire logic [63:0] rx_data, // Received data, byte 0 on top
  input wire logic id_start, // Start of identifier field
  input wire logic tx_done, // Outgoing frame sent successfully
  input wire logic tx_lost, // Outgoing frame abandoned, retry later
  input wire logic bit_chk, // RTR or SRR bit being checked
  input wire logic bit_sent, // Bit level sent
  input wire logic bit_rx, // Bit level sampled
  output logic rx_ready, // A serial buffer is free
  output logic tx_valid, // Outgoing frame offered
  output logic [28:0] tx_id, // Outgoing identifier
  output logic tx_ide, // Outgoing frame is extended
  output logic tx_rtr, // Outgoing frame is remote
  output logic tx_srr, // Outgoing SRR bit
  output logic [3:0] tx_dlc, // Outgoing length code
  output logic [63:0] tx_data, // Outgoing data, byte 0 on top
  output logic arb_lost, // Arbitration lost pulse
  output logic bit_err, // Bit error pulse
  output logic bit_ok // Bit matched pulse
);
  logic [15:0] mb_reg [NUM_MB][MB_WORDS];
  logic [15:0] mb_next [NUM_MB][MB_WORDS];
  logic [28:0] gmask_reg, gmask_next, m14_reg, m14_next, m15_reg, m15_next;
  logic [15:0] timer_reg, timer_next, ts_cap_reg, ts_cap_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic lock_on_reg, lock_on_next;
  logic [3:0] lock_idx_reg, lock_idx_next;
  cmb_frame_t sb_reg [2];
  cmb_frame_t sb_next [2];
  logic [1:0] sb_full_reg, sb_full_next;
  logic sb_wr_reg, sb_wr_next, sb_rd_reg, sb_rd_next;
  cmb_move_t mv_state_reg, mv_state_next;
  logic [4:0] mv_cnt_reg, mv_cnt_next;
  logic [3:0] mv_idx_reg, mv_idx_next;
  logic rx_ready_reg, rx_ready_next;
  logic tx_valid_reg, tx_valid_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [28:0] tx_id_reg, tx_id_next;
  logic tx_ide_reg, tx_ide_next, tx_rtr_reg, tx_rtr_next, tx_srr_reg, tx_srr_next;
  logic [3:0] tx_dlc_reg, tx_dlc_next;
  logic [63:0] tx_data_reg, tx_data_next;
  logic arb_lost_reg, arb_lost_next, bit_err_reg, bit_err_next;
  logic bit_ok_reg, bit_ok_next;
  logic [NUM_MB-1:0][15:0] ctrl_v, up_v, lo_v;
  logic hit;
  logic [3:0] hit_idx;
  logic acc_first, acc_done, is_mb;
  logic [3:0] a_mb;
  logic [2:0] a_w;

  assign acc_first = psel & penable & ~pready_reg;
  assign acc_done = psel & penable & pready_reg;
  assign is_mb = paddr < ADDR_MB_LIMIT;
  assign a_mb = paddr[8:5];
  assign a_w = paddr[4:2];

  genvar g;
  generate
    for (g = 0; g < NUM_MB; g++) begin : g_view
      assign ctrl_v[g] = mb_reg[g][W_CTRL];
      assign up_v[g] = mb_reg[g][W_UPPER];
      assign lo_v[g] = mb_reg[g][W_LOWER];
    end
  endgenerate

  cmb_filter u_filter (
    .in_id(rx_id),
    .in_ide(rx_ide),
    .in_rtr(rx_rtr),
    .ctrl(ctrl_v),
    .up(up_v),
    .lo(lo_v),
    .gmask(gmask_reg),
    .m14(m14_reg),
    .m15(m15_reg),
    .hit(hit),
    .hit_idx(hit_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB access, masks, timer and lock
  always_comb begin
    logic [15:0] w;
    logic busy_here;
    w = mb_reg[a_mb][a_w];
    busy_here = (mv_state_reg == MV_BUSY) && (mv_idx_reg == a_mb);
    gmask_next = gmask_reg;
    m14_next = m14_reg;
    m15_next = m15_reg;
    timer_next = timer_reg + 16'h0001;
    ts_cap_next = id_start ? timer_reg : ts_cap_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    pready_next = acc_first;
    lock_on_next = lock_on_reg;
    lock_idx_next = lock_idx_reg;
    if (acc_first) begin
      pslverr_next = 1'b0;
      if (is_mb) begin
        if (a_w == W_CTRL && busy_here) begin
          w[CODE_LSB] = 1'b1;
        end
        prdata_next = {16'h0000, w};
      end else if (paddr == ADDR_MASK_GLOBAL) begin
        prdata_next = {3'h0, gmask_reg};
      end else if (paddr == ADDR_MASK_14) begin
        prdata_next = {3'h0, m14_reg};
      end else if (paddr == ADDR_MASK_15) begin
        prdata_next = {3'h0, m15_reg};
      end else if (paddr == ADDR_TIMER) begin
        prdata_next = {16'h0000, timer_reg};
      end else begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b1;
      end
    end
    if (acc_done && !pwrite) begin
      if (is_mb && a_w == W_CTRL) begin
        lock_on_next = 1'b0;
        if (!w[CODE_DIR_BIT] && !busy_here) begin
          lock_on_next = 1'b1;
          lock_idx_next = a_mb;
        end
      end else if (paddr == ADDR_TIMER) begin
        lock_on_next = 1'b0;
      end
    end
    if (acc_done && pwrite) begin
      if (paddr == ADDR_MASK_GLOBAL) begin
        gmask_next = pwdata[28:0];
      end else if (paddr == ADDR_MASK_14) begin
        m14_next = pwdata[28:0];
      end else if (paddr == ADDR_MASK_15) begin
        m15_next = pwdata[28:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gmask_reg <= MASK_RESET;
      m14_reg <= MASK_RESET;
      m15_reg <= MASK_RESET;
      timer_reg <= 16'h0000;
      ts_cap_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      lock_on_reg <= 1'b0;
      lock_idx_reg <= 4'h0;
    end else if (ce) begin
      gmask_reg <= gmask_next;
      m14_reg <= m14_next;
      m15_reg <= m15_next;
      timer_reg <= timer_next;
      ts_cap_reg <= ts_cap_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      lock_on_reg <= lock_on_next;
      lock_idx_reg <= lock_idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers, serial staging, moves and transmit choice
  always_comb begin
    cmb_frame_t f;
    logic [3:0] c;
    logic [3:0] nc;
    logic brtr;
    logic found;
    logic [3:0] sel;
    mb_next = mb_reg;
    sb_next = sb_reg;
    sb_full_next = sb_full_reg;
    sb_wr_next = sb_wr_reg;
    sb_rd_next = sb_rd_reg;
    mv_state_next = mv_state_reg;
    mv_cnt_next = mv_cnt_reg;
    mv_idx_next = mv_idx_reg;
    tx_valid_next = tx_valid_reg;
    tx_idx_next = tx_idx_reg;
    tx_id_next = tx_id_reg;
    tx_ide_next = tx_ide_reg;
    tx_rtr_next = tx_rtr_reg;
    tx_srr_next = tx_srr_reg;
    tx_dlc_next = tx_dlc_reg;
    tx_data_next = tx_data_reg;
    f = sb_reg[sb_rd_reg];
    c = 4'h0;
    nc = 4'h0;
    brtr = 1'b0;
    found = 1'b0;
    sel = 4'h0;
    if (acc_done && pwrite && is_mb) begin
      mb_next[a_mb][a_w] = pwdata[15:0];
    end
    if (rx_valid && hit) begin
      if (rx_rtr) begin
        mb_next[hit_idx][W_CTRL][CODE_LSB+3:CODE_LSB] = TX_ONCE_ANSWER;
      end else if (!sb_full_reg[sb_wr_reg]) begin
        sb_next[sb_wr_reg] = {hit_idx, rx_id, rx_ide, rx_rtr, rx_srr, rx_dlc,
                              rx_data, ts_cap_reg};
        sb_full_next[sb_wr_reg] = 1'b1;
        sb_wr_next = ~sb_wr_reg;
      end
    end
    case (mv_state_reg)
      MV_IDLE: begin
        if (sb_full_reg[sb_rd_reg] && !(lock_on_reg && lock_idx_reg == f.idx)) begin
          mv_state_next = MV_BUSY;
          mv_cnt_next = MOVE_CYC - 5'h1;
          mv_idx_next = f.idx;
        end
      end
      MV_BUSY: begin
        if (mv_cnt_reg != 5'h0) begin
          mv_cnt_next = mv_cnt_reg - 5'h1;
        end else begin
          c = mb_reg[f.idx][W_CTRL][CODE_LSB+3:CODE_LSB];
          nc = (c == RX_EMPTY) ? RX_FULL : RX_OVERRUN;
          if (c == RX_EMPTY || c == RX_FULL || c == RX_OVERRUN) begin
            mb_next[f.idx][W_CTRL] = {f.ts[15:8], nc, f.dlc};
            if (f.ide) begin
              mb_next[f.idx][W_UPPER] = {f.id[28:18], f.srr, 1'b1, f.id[17:15]};
              mb_next[f.idx][W_LOWER] = {f.id[14:0], f.rtr};
            end else begin
              mb_next[f.idx][W_UPPER] = {f.id[28:18], f.rtr, 4'h0};
              mb_next[f.idx][W_LOWER] = f.ts;
            end
            for (int k = 0; k < 4; k++) begin
              mb_next[f.idx][3+k] = f.data[63-16*k -: 16];
            end
          end
          sb_full_next[sb_rd_reg] = 1'b0;
          sb_rd_next = ~sb_rd_reg;
          mv_state_next = MV_IDLE;
        end
      end
      default: begin
        mv_state_next = MV_IDLE;
      end
    endcase
    if (tx_valid_reg) begin
      c = mb_reg[tx_idx_reg][W_CTRL][CODE_LSB+3:CODE_LSB];
      if (tx_done) begin
        tx_valid_next = 1'b0;
        nc = c;
        if (c == TX_ONCE) begin
          nc = tx_rtr_reg ? RX_EMPTY : TX_NOT_READY;
        end else if (c == TX_ONCE_ANSWER) begin
          nc = TX_ANSWER;
        end
        mb_next[tx_idx_reg][W_CTRL] = {ts_cap_reg[15:8], nc,
                                       mb_reg[tx_idx_reg][W_CTRL][3:0]};
        if (!tx_ide_reg) begin
          mb_next[tx_idx_reg][W_LOWER] = ts_cap_reg;
        end
      end else if (tx_lost) begin
        tx_valid_next = 1'b0;
      end
    end else begin
      for (int i = NUM_MB - 1; i >= 0; i--) begin
        c = mb_reg[i][W_CTRL][CODE_LSB+3:CODE_LSB];
        brtr = mb_reg[i][W_UPPER][UP_IDE_BIT] ? mb_reg[i][W_LOWER][LO_RTR_BIT] :
               mb_reg[i][W_UPPER][UP_SRR_BIT];
        if (c == TX_ONCE || (c == TX_ONCE_ANSWER && !brtr)) begin
          found = 1'b1;
          sel = i[3:0];
        end
      end
      if (found) begin
        tx_valid_next = 1'b1;
        tx_idx_next = sel;
        tx_ide_next = mb_reg[sel][W_UPPER][UP_IDE_BIT];
        if (mb_reg[sel][W_UPPER][UP_IDE_BIT]) begin
          tx_id_next = {mb_reg[sel][W_UPPER][15:5], mb_reg[sel][W_UPPER][2:0],
                        mb_reg[sel][W_LOWER][15:1]};
          tx_rtr_next = mb_reg[sel][W_LOWER][LO_RTR_BIT];
          tx_srr_next = mb_reg[sel][W_UPPER][UP_SRR_BIT];
        end else begin
          tx_id_next = {mb_reg[sel][W_UPPER][15:5], 18'h00000};
          tx_rtr_next = mb_reg[sel][W_UPPER][UP_SRR_BIT];
          tx_srr_next = 1'b1;
        end
        tx_dlc_next = tx_rtr_next ? 4'h0 : mb_reg[sel][W_CTRL][3:0];
        tx_data_next = {mb_reg[sel][3], mb_reg[sel][4], mb_reg[sel][5], mb_reg[sel][6]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MB; i++) begin
        for (int j = 0; j < MB_WORDS; j++) begin
          mb_reg[i][j] <= WORD_RESET;
        end
      end
      sb_reg[0] <= '0;
      sb_reg[1] <= '0;
      sb_full_reg <= 2'h0;
      sb_wr_reg <= 1'b0;
      sb_rd_reg <= 1'b0;
      mv_state_reg <= MV_IDLE;
      mv_cnt_reg <= 5'h00;
      mv_idx_reg <= 4'h0;
      tx_valid_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_id_reg <= 29'h0;
      tx_ide_reg <= 1'b0;
      tx_rtr_reg <= 1'b0;
      tx_srr_reg <= 1'b0;
      tx_dlc_reg <= 4'h0;
      tx_data_reg <= 64'h0;
    end else if (ce) begin
      mb_reg <= mb_next;
      sb_reg <= sb_next;
      sb_full_reg <= sb_full_next;
      sb_wr_reg <= sb_wr_next;
      sb_rd_reg <= sb_rd_next;
      mv_state_reg <= mv_state_next;
      mv_cnt_reg <= mv_cnt_next;
      mv_idx_reg <= mv_idx_next;
      tx_valid_reg <= tx_valid_next;
      tx_idx_reg <= tx_idx_next;
      tx_id_reg <= tx_id_next;
      tx_ide_reg <= tx_ide_next;
      tx_rtr_reg <= tx_rtr_next;
      tx_srr_reg <= tx_srr_next;
      tx_dlc_reg <= tx_dlc_next;
      tx_data_reg <= tx_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RTR/SRR bit check and receive readiness
  always_comb begin
    arb_lost_next = bit_chk & bit_sent & ~bit_rx;
    bit_err_next = bit_chk & ~bit_sent & bit_rx;
    bit_ok_next = bit_chk & (bit_sent == bit_rx);
    rx_ready_next = (sb_full_next != 2'h3);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_lost_reg <= 1'b0;
      bit_err_reg <= 1'b0;
      bit_ok_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
    end else if (ce) begin
      arb_lost_reg <= arb_lost_next;
      bit_err_reg <= bit_err_next;
      bit_ok_reg <= bit_ok_next;
      rx_ready_reg <= rx_ready_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_ready = rx_ready_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_id = tx_id_reg;
  assign tx_ide = tx_ide_reg;
  assign tx_rtr = tx_rtr_reg;
  assign tx_srr = tx_srr_reg;
  assign tx_dlc = tx_dlc_reg;
  assign tx_data = tx_data_reg;
  assign arb_lost = arb_lost_reg;
  assign bit_err = bit_err_reg;
  assign bit_ok = bit_ok_reg;
endmodule : cmb_manager

/* File: logic/cmb_pkg.sv */
// Purpose: Constants and types for the CAN message buffer manager.
// Assumes: 200 MHz pclk, APB register access, frame-level link logic on pclk.
// Notes: Function
package cmb_pkg;
  localparam int NUM_MB = 16;
  localparam int MB_WORDS = 8;
  localparam logic [3:0] RX_INACTIVE = 4'h0;
  localparam logic [3:0] RX_EMPTY = 4'h4;
  localparam logic [3:0] RX_FULL = 4'h2;
  localparam logic [3:0] RX_OVERRUN = 4'h6;
  localparam logic [3:0] TX_NOT_READY = 4'h8;
  localparam logic [3:0] TX_ONCE = 4'hc;
  localparam logic [3:0] TX_ANSWER = 4'ha;
  localparam logic [3:0] TX_ONCE_ANSWER = 4'he;
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_UPPER = 3'h1;
  localparam logic [2:0] W_LOWER = 3'h2;
  localparam int CODE_LSB = 4;
  localparam int CODE_DIR_BIT = 7;
  localparam int UP_SRR_BIT = 4;
  localparam int UP_IDE_BIT = 3;
  localparam int LO_RTR_BIT = 0;
  localparam logic [9:0] ADDR_MB_LIMIT = 10'h200;
  localparam logic [9:0] ADDR_MASK_GLOBAL = 10'h200;
  localparam logic [9:0] ADDR_MASK_14 = 10'h204;
  localparam logic [9:0] ADDR_MASK_15 = 10'h208;
  localparam logic [9:0] ADDR_TIMER = 10'h20c;
  localparam logic [28:0] MASK_RESET = 29'h1fffffff;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BUSY_LIMIT_NS = 100;
  localparam int BUSY_LIMIT_CYC = BUSY_LIMIT_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [4:0] MOVE_CYC = 5'h4;
  typedef enum logic {MV_IDLE, MV_BUSY} cmb_move_t;
  typedef struct packed {
    logic [3:0] idx;
    logic [28:0] id;
    logic ide;
    logic rtr;
    logic srr;
    logic [3:0] dlc;
    logic [63:0] data;
    logic [15:0] ts;
  } cmb_frame_t;
endpackage : cmb_pkg

/* File: logic/cmb_filter.sv */
// Purpose: Acceptance filter over all message buffers.
// Assumes: Buffer words and masks come straight from registers.
// Notes: Combinational; lowest matching index wins.
`timescale 1ns/1ps
module cmb_filter import cmb_pkg::*; (
  input wire logic [28:0] in_id, // Incoming identifier
  input wire logic in_ide, // Incoming frame is extended
  input wire logic in_rtr, // Incoming frame is remote
  input wire logic [NUM_MB-1:0][15:0] ctrl, // Control words
  input wire logic [NUM_MB-1:0][15:0] up, // Identifier upper words
  input wire logic [NUM_MB-1:0][15:0] lo, // Identifier lower words
  input wire logic [28:0] gmask, // Global mask
  input wire logic [28:0] m14, // Mask of buffer 14
  input wire logic [28:0] m15, // Mask of buffer 15
  output logic hit, // Some buffer matches
  output logic [3:0] hit_idx // Lowest matching buffer
);
  logic [NUM_MB-1:0] match;
  genvar g;
  generate
    for (g = 0; g < NUM_MB; g++) begin : g_mb
      logic [28:0] m;
      logic [28:0] ref_id;
      logic [28:0] cmpm;
      logic [3:0] c;
      logic brtr;
      logic code_ok;
      assign m = (g == 14) ? m14 : (g == 15) ? m15 : gmask;
      assign ref_id = {up[g][15:5], up[g][2:0], lo[g][15:1]};
      assign cmpm = in_ide ? m : {m[28:18], 18'h0};
      assign c = ctrl[g][CODE_LSB+3:CODE_LSB];
      assign brtr = up[g][UP_IDE_BIT] ? lo[g][LO_RTR_BIT] : up[g][UP_SRR_BIT];
      assign code_ok = in_rtr ? (c == TX_ANSWER && !brtr) :
                       (c == RX_EMPTY || c == RX_FULL || c == RX_OVERRUN);
      assign match[g] = code_ok && (up[g][UP_IDE_BIT] == in_ide) &&
                        (((ref_id ^ in_id) & cmpm) == 29'h0);
    end
  endgenerate

  always_comb begin
    hit = |match;
    hit_idx = 4'h0;
    for (int i = NUM_MB - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_idx = i[3:0];
      end
    end
  end
endmodule : cmb_filter

/* File: sim/cmb_link_model.sv */
// Purpose: Far-side link model that answers offered frames.
// Assumes: Same clock as the buffer manager.
// Notes: Sends a one-cycle done pulse lat+1 cycles after an offer.
`timescale 1ns/1ps
module cmb_link_model (
  input wire logic pclk, // Clock
  input wire logic [3:0] lat, // Answer delay
  input wire logic tx_valid, // Frame offered
  output logic tx_done // Frame sent pulse
);
  logic [3:0] cnt_reg;
  initial cnt_reg = 4'h0;
  initial tx_done = 1'b0;
  always @(posedge pclk) begin
    tx_done <= 1'b0;
    if (!tx_valid || tx_done) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg == lat) begin
      tx_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : cmb_link_model

/* File: sim/cmb_manager_properties.sv */
// Purpose: Port-level checks of the buffer manager.
// Assumes: One clock domain.
// Notes: Bound to every manager instance.
`timescale 1ns/1ps
module cmb_manager_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [9:0] paddr, // APB address
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic tx_valid, // Frame offered
  input wire logic tx_done, // Frame sent
  input wire logic tx_lost, // Frame withdrawn
  input wire logic tx_rtr, // Remote frame
  input wire logic [3:0] tx_dlc, // Length code
  input wire logic [28:0] tx_id, // Identifier
  input wire logic bit_chk, // Bit check strobe
  input wire logic bit_sent, // Bit sent
  input wire logic bit_rx, // Bit seen
  input wire logic arb_lost, // Lost flag
  input wire logic bit_err, // Error flag
  input wire logic bit_ok // Match flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence lost_s;
    ce && bit_chk && bit_sent && !bit_rx;
  endsequence
  sequence err_s;
    ce && bit_chk && !bit_sent && bit_rx;
  endsequence
  sequence fin_s;
    ce && tx_valid && (tx_done || tx_lost);
  endsequence
  arb_loss_a: assert property (lost_s |=> arb_lost && !bit_err && !bit_ok)
    else $error("loss not flagged");
  bit_error_a: assert property (err_s |=> bit_err && !arb_lost && !bit_ok)
    else $error("bit error not flagged");
  bit_match_a: assert property (ce && bit_chk && bit_sent == bit_rx |=> bit_ok && !bit_err)
    else $error("match not flagged");
  tx_finish_a: assert property (fin_s |=> !tx_valid)
    else $error("offer not withdrawn");
  tx_hold_a: assert property (tx_valid && !tx_done && !tx_lost |=> tx_valid && $stable(tx_id))
    else $error("offer changed");
  remote_len_a: assert property (tx_valid && tx_rtr |-> tx_dlc == 4'h0)
    else $error("remote frame has length");
  apb_wait_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (ce && pready |=> !pready)
    else $error("ready too long");
  unmapped_a: assert property (pready |-> pslverr == (paddr[9:2] >= 8'h84))
    else $error("error flag wrong");
endmodule : cmb_manager_properties

bind cmb_manager cmb_manager_properties i_props (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_done(tx_done), .tx_lost(tx_lost), .tx_rtr(tx_rtr),
  .tx_dlc(tx_dlc), .tx_id(tx_id), .bit_chk(bit_chk), .bit_sent(bit_sent), .bit_rx(bit_rx),
  .arb_lost(arb_lost), .bit_err(bit_err), .bit_ok(bit_ok));

/* File: sim/cmb_manager_test.sv */
// Purpose: Self-checking bench of the buffer manager.
// Assumes: APB master and link model on one clock.
// Notes: Reads and offers are checked from queues.
`timescale 1ns/1ps
module cmb_manager_test import cmb_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, rx_valid, rx_rtr, rx_ide, rx_srr;
  logic bit_chk, bit_sent, bit_rx, tx_done, tx_valid, tx_ide, tx_rtr, tx_srr, tv_d;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [28:0] rx_id, tx_id, ida;
  logic [3:0] tx_dlc, rx_dlc, lat;
  logic [63:0] rx_data, tx_data, n;
  logic ce, rx_ready;
  logic [63:0] rdq[$], txq[$];
  int errors, num_checks;
  cmb_manager i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide),
    .rx_rtr(rx_rtr), .rx_srr(rx_srr), .rx_dlc(rx_dlc), .rx_data(rx_data), .id_start(1'b0),
    .tx_done(tx_done), .tx_lost(1'b0), .bit_chk(bit_chk), .bit_sent(bit_sent), .bit_rx(bit_rx),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_id(tx_id), .tx_ide(tx_ide), .tx_rtr(tx_rtr),
    .tx_srr(tx_srr), .tx_dlc(tx_dlc), .tx_data(tx_data), .arb_lost(), .bit_err(), .bit_ok());
  cmb_link_model i_link (.pclk(pclk), .lat(lat), .tx_valid(tx_valid), .tx_done(tx_done));
  //////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  function automatic logic [9:0] mb(input int b, input int w);
    return 10'(b * 32 + w * 4);
  endfunction : mb
  function automatic logic [31:0] up(input logic [28:0] i);
    return {16'h0, i[28:18], 2'b11, i[17:15]};
  endfunction : up
  function automatic logic [31:0] lo(input logic [28:0] i, input logic r);
    return {16'h0, i[14:0], r};
  endfunction : lo
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] m = '1);
    if (!w) rdq.push_back({m, d & m});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send(input int b, input logic [28:0] id, input logic r, input logic [3:0] c);
    apb(1'b1, mb(b, 1), up(id));
    apb(1'b1, mb(b, 2), lo(id, r));
    apb(1'b1, mb(b, 0), {24'h0, c, 4'h5});
  endtask : send
  task automatic rx(input logic [28:0] id, input logic r, input logic [63:0] d);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_rtr <= r;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
  endtask : rx
  task automatic wait_tx();
    for (int i = 0; i < 40 && tx_done !== 1'b1; i++) @(posedge pclk);
    @(posedge pclk);
  endtask : wait_tx
  //////////////////////////////////////////
  always @(posedge pclk) begin
    tv_d <= tx_valid;
    if (psel && penable && pready && !pwrite) begin
      n = rdq.pop_front();
      check({32'h0, prdata & n[63:32]}, {32'h0, n[31:0]});
    end
    if (tx_valid && !tv_d) begin
      check(64'({tx_srr, tx_rtr, tx_ide, tx_dlc, tx_id}), txq.pop_front());
      check(tx_data, txq.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    errors++;
    summarize();
  end
  initial begin
    static logic [3:0] after [4] = '{RX_INACTIVE, TX_NOT_READY, RX_EMPTY, TX_ANSWER};
    {presetn, psel, penable, pwrite, rx_valid, rx_rtr, bit_chk, bit_sent, bit_rx, tv_d} = '0;
    {paddr, pwdata, rx_id, rx_data, lat} = '0;
    ce = 1'b1;
    {rx_ide, rx_srr, rx_dlc} = 6'h38;
    void'($urandom(32'h1987));
    repeat (12) @(posedge pclk);
    check(64'(rx_ready), 64'h0);
    presetn <= 1'b1;
    apb(1'b0, ADDR_MASK_GLOBAL, 32'(MASK_RESET));
    apb(1'b0, mb(0, 0), 32'h0);
    apb(1'b0, 10'h210, 32'h0);
    send(0, 29'h0, 1'b1, TX_NOT_READY);
    for (int k = 1; k < 4; k++) begin
      ida = 29'($urandom());
      lat <= 4'($urandom());
      txq.push_back(64'({2'b11, 1'b1, (k == 2) ? 4'h0 : 4'h5, ida} ^ {1'b0, k != 2, 34'h0}));
      txq.push_back({16'(k), 48'h0});
      apb(1'b1, mb(k, 3), 32'(k));
      send(k, ida, k == 2, (k == 3) ? TX_ONCE_ANSWER : TX_ONCE);
      wait_tx();
      apb(1'b0, mb(k, 0), {24'h0, after[k], 4'h5}, 32'h00ef);
    end
    txq.push_back(64'({3'b101, 4'h5, ida}));
    txq.push_back({16'h3, 48'h0});
    rx(ida, 1'b1, 64'h0);
    wait_tx();
    apb(1'b0, mb(3, 0), {24'h0, TX_ANSWER, 4'h5}, 32'h00ef);
    // Standard-format data frame from buffer 6
    txq.push_back(64'({3'b100, 4'h5, ida[28:18], 18'h0}));
    txq.push_back(64'h0);
    apb(1'b1, mb(6, 1), {16'h0, ida[28:18], 5'h0});
    apb(1'b1, mb(6, 0), {24'h0, TX_ONCE, 4'h5});
    wait_tx();
    apb(1'b0, mb(6, 0), {24'h0, TX_NOT_READY, 4'h5}, 32'h00ef);
    ida = 29'($urandom());
    apb(1'b1, ADDR_MASK_GLOBAL, 32'(MASK_RESET) & ~32'h1);
    send(4, ida, 1'b0, RX_EMPTY);
    send(5, ida, 1'b0, RX_EMPTY);
    rx(ida ^ 29'h1, 1'b0, 64'h1122334455667788);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(4, 0), {24'h0, RX_FULL, 4'h8}, 32'h00ff);
    apb(1'b0, mb(4, 1), up(ida));
    apb(1'b0, mb(4, 2), lo(ida ^ 29'h1, 1'b0));
    rx(ida, 1'b0, 64'haabb000000000000);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(4, 3), 32'h1122);
    apb(1'b0, mb(5, 0), {24'h0, RX_EMPTY, 4'h5}, 32'h00ff);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(4, 0), {24'h0, RX_OVERRUN, 4'h8}, 32'h00ff);
    apb(1'b0, mb(4, 3), 32'haabb);
    rx(ida, 1'b0, 64'h5566000000000000);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(4, 3), 32'haabb);
    apb(1'b0, ADDR_TIMER, 32'h0, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(4, 3), 32'h5566);
    apb(1'b1, ADDR_MASK_14, 32'h0);
    send(14, ~ida, 1'b0, RX_EMPTY);
    rx(29'($urandom()), 1'b0, 64'h0);
    // Frozen clock enable holds the staged frame back
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, mb(14, 0), {24'h0, 4'h5, 4'h5}, 32'h00ff);
    repeat (8) @(posedge pclk);
    apb(1'b0, mb(14, 0), {24'h0, RX_FULL, 4'h8}, 32'h00ff);
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      bit_chk <= 1'b1;
      {bit_rx, bit_sent} <= 2'(k);
    end
    @(posedge pclk);
    bit_chk <= 1'b0;
    check(64'(txq.size()), 64'h0);
    check(64'(rx_ready), 64'h1);
    summarize();
  end
endmodule : cmb_manager_test
